// >>> rtl/power_mode_controller.v
`include "pwr_seq_defines.vh"
`default_nettype none
module power_mode_controller (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [3:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output reg irq_o,
  input wire wait_for_interrupt_instr_i,
  input wire irq_pending_i,
  input wire async_wake_i,
  input wire leakage_wake_i,
  input wire power_good_i,
  output reg [3:0] mode_o,
  output reg core_sleep_o,
  output reg core_deep_o,
  output reg periph_clk_on_o,
  output reg fast_clk_on_o,
  output reg low_voltage_detect_on_o,
  output reg nested_irq_on_o,
  output reg async_wakeup_on_o,
  output reg leakage_wakeup_on_o,
  output reg regulator_low_o,
  output reg sram_l_on_o,
  output reg sram_u_on_o,
  output reg sram_u_part_o,
  output reg regfile_on_o,
  output reg main_power_o,
  output reg pin_hold_o,
  output reg flash_slow_o,
  output reg slow_clk_en_o,
  output reg wake_reset_o,
  output reg wake_flag_o
);
  reg [3:0] mode_q;
  reg [3:0] mode_d;
  reg [7:0] ctrl_q;
  reg [3:0] ev_q;
  reg [3:0] ev_d;
  reg [3:0] mask_q;
  reg [3:0] ev_set;
  reg [2:0] pg_q;
  reg [2:0] aw_q;
  reg [2:0] lw_q;
  reg [4:0] fdiv_q;
  reg [2:0] vdiv_q;
  reg wflag_q;
  wire pg_s = pg_q[2] & pg_q[1];
  wire aw_s = aw_q[2] & aw_q[1];
  wire lw_s = lw_q[2] & lw_q[1];
  wire vlp = ctrl_q[`CTRL_VLP_BIT];
  wire [2:0] tgt = ctrl_q[`CTRL_TGT_LSB+2:`CTRL_TGT_LSB];
  wire wr = cyc_i & stb_i & we_i & ~ack_o;
  wire p_sleep, p_deep, p_pclk, p_fast_core_clock, p_lvd, p_nested_irq_controller, p_async_wakeup_irq_unit, p_leakage_wakeup_unit;
  wire p_reg, p_sl, p_su, p_sup, p_rf, p_main;

  mode_policy u_policy (
    .mode_i(mode_q),
    .core_sleep_o(p_sleep),
    .core_deep_o(p_deep),
    .periph_clk_on_o(p_pclk),
    .fast_clk_on_o(p_fast_core_clock),
    .lvd_on_o(p_lvd),
    .nested_irq_controller_on_o(p_nested_irq_controller),
    .async_wakeup_irq_unit_on_o(p_async_wakeup_irq_unit),
    .leakage_wakeup_unit_on_o(p_leakage_wakeup_unit),
    .reg_low_power_o(p_reg),
    .sram_l_on_o(p_sl),
    .sram_u_on_o(p_su),
    .sram_u_part_o(p_sup),
    .regfile_on_o(p_rf),
    .main_power_o(p_main)
  );

  // Next mode; wake sources are sampled only in the modes that own them
  always @* begin
    mode_d = mode_q;
    ev_set = 4'h0;
    case (mode_q)
      `MODE_RUN, `MODE_VLP_RUN: begin
        if (wait_for_interrupt_instr_i) begin
          ev_set[`EV_ENTER_BIT] = 1'b1;
          if (ctrl_q[`CTRL_WAIT_BIT]) begin
            mode_d = vlp ? `MODE_VLP_WAIT : `MODE_WAIT;
          end else if (vlp) begin
            if (tgt == `TGT_STOP) begin
              mode_d = `MODE_VLP_STOP;
            end else if (tgt == `TGT_BAT) begin
              mode_d = `MODE_BAT;
            end else if (tgt > `TGT_BAT) begin
              // Unused target codes would land outside the mode table
              ev_set[`EV_REJECT_BIT] = 1'b1;
              ev_set[`EV_ENTER_BIT] = 1'b0;
            end else begin
              mode_d = `MODE_LL_STOP + {1'b0, tgt} - 4'h1;
            end
          end else begin
            case (tgt)
              `TGT_STOP: mode_d = `MODE_STOP;
              `TGT_LL_STOP: mode_d = `MODE_LL_STOP;
              `TGT_LVL3: mode_d = `MODE_LVL3;
              `TGT_LVL2: mode_d = `MODE_LVL2;
              `TGT_LVL1: mode_d = `MODE_LVL1;
              `TGT_BAT: mode_d = `MODE_BAT;
              default: begin
                mode_d = mode_q;
                ev_set[`EV_REJECT_BIT] = 1'b1;
                ev_set[`EV_ENTER_BIT] = 1'b0;
              end
            endcase
          end
        end else if (mode_q == `MODE_RUN && vlp) begin
          mode_d = `MODE_VLP_RUN;
        end else if (mode_q == `MODE_VLP_RUN && !vlp) begin
          mode_d = `MODE_RUN;
        end
      end
      `MODE_WAIT, `MODE_VLP_WAIT: begin
        if (irq_pending_i) begin
          mode_d = (mode_q == `MODE_WAIT) ? `MODE_RUN : `MODE_VLP_RUN;
          ev_set[`EV_WAKE_BIT] = 1'b1;
        end
      end
      `MODE_STOP, `MODE_VLP_STOP: begin
        if (aw_s) begin
          mode_d = (mode_q == `MODE_STOP) ? `MODE_RUN : `MODE_VLP_RUN;
          ev_set[`EV_WAKE_BIT] = 1'b1;
        end
      end
      `MODE_LL_STOP: begin
        if (lw_s) begin
          mode_d = `MODE_RUN;
          ev_set[`EV_WAKE_BIT] = 1'b1;
        end
      end
      `MODE_LVL3, `MODE_LVL2, `MODE_LVL1: begin
        if (lw_s) begin
          mode_d = `MODE_RUN;
          ev_set[`EV_RESETWAKE_BIT] = 1'b1;
        end
      end
      `MODE_BAT: begin
        if (pg_s) begin
          mode_d = `MODE_RUN;
          ev_set[`EV_RESETWAKE_BIT] = 1'b1;
        end
      end
      default: mode_d = `MODE_RUN;
    endcase
  end

  // Set beats write-one-to-clear in the same cycle
  always @* begin
    ev_d = ev_q;
    if (wr && adr_i == `ADDR_IRQ_STAT && sel_i[0]) begin
      ev_d = ev_q & ~dat_i[3:0];
    end
    ev_d = ev_d | ev_set;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= `MODE_RUN;
      ctrl_q <= `CTRL_RESET;
      ev_q <= 4'h0;
      mask_q <= 4'h0;
      pg_q <= 3'h0;
      aw_q <= 3'h0;
      lw_q <= 3'h0;
      fdiv_q <= 5'h00;
      vdiv_q <= 3'h0;
      wflag_q <= 1'b0;
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      pg_q <= {pg_q[1:0], power_good_i};
      aw_q <= {aw_q[1:0], async_wake_i};
      lw_q <= {lw_q[1:0], leakage_wake_i};
      mode_q <= mode_d;
      ev_q <= ev_d;
      irq_o <= |(ev_d & mask_q);
      if (ev_set[`EV_RESETWAKE_BIT] && mode_q != `MODE_BAT) begin
        wflag_q <= 1'b1;
      end else if (mode_q == `MODE_RUN && irq_pending_i) begin
        wflag_q <= 1'b0;
      end
      // Divider counters only run while the slow strobes are wanted
      if (!p_reg) begin
        fdiv_q <= 5'h00;
        vdiv_q <= 3'h0;
      end else begin
        if (fdiv_q == `FLASH_DIV - 1) begin
          fdiv_q <= 5'h00;
        end else begin
          fdiv_q <= fdiv_q + 5'h01;
        end
        if (vdiv_q == `VLP_DIV - 1) begin
          vdiv_q <= 3'h0;
        end else begin
          vdiv_q <= vdiv_q + 3'h1;
        end
      end
      ack_o <= cyc_i & stb_i & ~ack_o;
      dat_o <= 32'h0000_0000;
      if (cyc_i && stb_i && !ack_o) begin
        if (we_i) begin
          if (adr_i == `ADDR_CTRL && sel_i[0]) begin
            ctrl_q <= dat_i[7:0];
          end
          if (adr_i == `ADDR_IRQ_MASK && sel_i[0]) begin
            mask_q <= dat_i[3:0];
          end
        end else begin
          case (adr_i)
            `ADDR_CTRL: dat_o <= {24'h000000, ctrl_q};
            `ADDR_STAT: dat_o <= {27'h0000000, wflag_q, mode_q};
            `ADDR_IRQ_STAT: dat_o <= {28'h0000000, ev_q};
            `ADDR_IRQ_MASK: dat_o <= {28'h0000000, mask_q};
            default: dat_o <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // Controls follow the registered mode one cycle later; the slow strobes and wake flag also move between transitions
  always @(posedge clk_i) begin
    if (rst_i) begin
      mode_o <= `MODE_RUN;
      core_sleep_o <= 1'b0;
      core_deep_o <= 1'b0;
      periph_clk_on_o <= 1'b1;
      fast_clk_on_o <= 1'b1;
      low_voltage_detect_on_o <= 1'b1;
      nested_irq_on_o <= 1'b1;
      async_wakeup_on_o <= 1'b0;
      leakage_wakeup_on_o <= 1'b0;
      regulator_low_o <= 1'b0;
      sram_l_on_o <= 1'b1;
      sram_u_on_o <= 1'b1;
      sram_u_part_o <= 1'b0;
      regfile_on_o <= 1'b1;
      main_power_o <= 1'b1;
      pin_hold_o <= 1'b0;
      flash_slow_o <= 1'b0;
      slow_clk_en_o <= 1'b0;
      wake_reset_o <= 1'b0;
      wake_flag_o <= 1'b0;
    end else if (ce_i) begin
      mode_o <= mode_q;
      core_sleep_o <= p_sleep;
      core_deep_o <= p_deep;
      periph_clk_on_o <= p_pclk;
      fast_clk_on_o <= p_fast_core_clock;
      low_voltage_detect_on_o <= p_lvd;
      nested_irq_on_o <= p_nested_irq_controller;
      async_wakeup_on_o <= p_async_wakeup_irq_unit;
      leakage_wakeup_on_o <= p_leakage_wakeup_unit;
      regulator_low_o <= p_reg;
      sram_l_on_o <= p_sl;
      sram_u_on_o <= p_su;
      sram_u_part_o <= p_sup;
      regfile_on_o <= p_rf;
      main_power_o <= p_main;
      // Pins freeze in any mode other than normal run and low-power run
      pin_hold_o <= (mode_q != `MODE_RUN) && (mode_q != `MODE_VLP_RUN);
      flash_slow_o <= p_reg && (fdiv_q == 5'h00);
      slow_clk_en_o <= p_reg && (vdiv_q == 3'h0);
      wake_reset_o <= ev_set[`EV_RESETWAKE_BIT];
      wake_flag_o <= wflag_q;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/pwr_seq_defines.vh
// Operation
// - Eleven operating modes, current mode held
// - Reset leaves chip in normal run
// - Each run mode has wait and stop
// - Wait-for-interrupt enters configured wait or stop
// - Pin output states held in every mode except normal and low-power run
// - Normal wait: core sleeps, interrupt wakes
// - Normal stop: peripheral clock off, fast clock on, detect on, async wake
// - Low-power run: detect off, slow flash, 4 MHz
// - Low-power wait: core asleep, fast clock on
// - Low-power stop: clocks off, SRAM kept, async wake
// - Leakage stop: state kept, wake unit wakes
// - Level three keeps both SRAM regions
// - Level two keeps part of upper SRAM
// - Level one keeps only two register files
// - Level wake goes through reset, flag set
// - Battery-only powers only backup domain
`ifndef PWR_SEQ_DEFINES_VH
`define PWR_SEQ_DEFINES_VH
`define MODE_RUN 4'h0
`define MODE_WAIT 4'h1
`define MODE_STOP 4'h2
`define MODE_VLP_RUN 4'h3
`define MODE_VLP_WAIT 4'h4
`define MODE_VLP_STOP 4'h5
`define MODE_LL_STOP 4'h6
`define MODE_LVL3 4'h7
`define MODE_LVL2 4'h8
`define MODE_LVL1 4'h9
`define MODE_BAT 4'hA
`define TGT_STOP 3'h0
`define TGT_LL_STOP 3'h1
`define TGT_LVL3 3'h2
`define TGT_LVL2 3'h3
`define TGT_LVL1 3'h4
`define TGT_BAT 3'h5
`define ADDR_CTRL 4'h0
`define ADDR_STAT 4'h1
`define ADDR_IRQ_STAT 4'h2
`define ADDR_IRQ_MASK 4'h3
`define CTRL_RESET 8'h00
`define CTRL_VLP_BIT 0
`define CTRL_DEEP_BIT 1
`define CTRL_TGT_LSB 2
`define CTRL_WAIT_BIT 5
`define EV_ENTER_BIT 0
`define EV_WAKE_BIT 1
`define EV_RESETWAKE_BIT 2
`define EV_REJECT_BIT 3
`define CORE_CLK_HZ 20000000
`define FLASH_SLOW_HZ 1000000
`define VLP_CLK_HZ 4000000
`define FLASH_DIV (`CORE_CLK_HZ / `FLASH_SLOW_HZ)
`define VLP_DIV (`CORE_CLK_HZ / `VLP_CLK_HZ)
`endif

// >>> rtl/mode_policy.v
`include "pwr_seq_defines.vh"
`default_nettype none
module mode_policy (
  input wire [3:0] mode_i,
  output reg core_sleep_o,
  output reg core_deep_o,
  output reg periph_clk_on_o,
  output reg fast_clk_on_o,
  output reg lvd_on_o,
  output reg nested_irq_controller_on_o,
  output reg async_wakeup_irq_unit_on_o,
  output reg leakage_wakeup_unit_on_o,
  output reg reg_low_power_o,
  output reg sram_l_on_o,
  output reg sram_u_on_o,
  output reg sram_u_part_o,
  output reg regfile_on_o,
  output reg main_power_o
);
  always @* begin
    core_sleep_o = 1'b0;
    core_deep_o = 1'b0;
    periph_clk_on_o = 1'b1;
    fast_clk_on_o = 1'b1;
    lvd_on_o = 1'b1;
    nested_irq_controller_on_o = 1'b1;
    async_wakeup_irq_unit_on_o = 1'b0;
    leakage_wakeup_unit_on_o = 1'b0;
    reg_low_power_o = 1'b0;
    sram_l_on_o = 1'b1;
    sram_u_on_o = 1'b1;
    sram_u_part_o = 1'b0;
    regfile_on_o = 1'b1;
    main_power_o = 1'b1;
    case (mode_i)
      `MODE_RUN: begin
      end
      `MODE_WAIT: begin
        core_sleep_o = 1'b1;
      end
      `MODE_STOP: begin
        core_sleep_o = 1'b1;
        core_deep_o = 1'b1;
        periph_clk_on_o = 1'b0;
        nested_irq_controller_on_o = 1'b0;
        async_wakeup_irq_unit_on_o = 1'b1;
      end
      `MODE_VLP_RUN: begin
        lvd_on_o = 1'b0;
        reg_low_power_o = 1'b1;
      end
      `MODE_VLP_WAIT: begin
        core_sleep_o = 1'b1;
        lvd_on_o = 1'b0;
        reg_low_power_o = 1'b1;
      end
      `MODE_VLP_STOP: begin
        core_sleep_o = 1'b1;
        core_deep_o = 1'b1;
        periph_clk_on_o = 1'b0;
        fast_clk_on_o = 1'b0;
        lvd_on_o = 1'b0;
        nested_irq_controller_on_o = 1'b0;
        async_wakeup_irq_unit_on_o = 1'b1;
        reg_low_power_o = 1'b1;
      end
      `MODE_LL_STOP, `MODE_LVL3, `MODE_LVL2, `MODE_LVL1: begin
        core_sleep_o = 1'b1;
        core_deep_o = 1'b1;
        periph_clk_on_o = 1'b0;
        fast_clk_on_o = 1'b0;
        lvd_on_o = 1'b0;
        nested_irq_controller_on_o = 1'b0;
        leakage_wakeup_unit_on_o = 1'b1;
        reg_low_power_o = 1'b1;
        if (mode_i == `MODE_LVL2) begin
          sram_l_on_o = 1'b0;
          sram_u_on_o = 1'b0;
          sram_u_part_o = 1'b1;
        end
        if (mode_i == `MODE_LVL1) begin
          sram_l_on_o = 1'b0;
          sram_u_on_o = 1'b0;
        end
      end
      `MODE_BAT: begin
        core_sleep_o = 1'b1;
        core_deep_o = 1'b1;
        periph_clk_on_o = 1'b0;
        fast_clk_on_o = 1'b0;
        lvd_on_o = 1'b0;
        nested_irq_controller_on_o = 1'b0;
        sram_l_on_o = 1'b0;
        sram_u_on_o = 1'b0;
        regfile_on_o = 1'b0;
        main_power_o = 1'b0;
      end
      default: begin
      end
    endcase
  end
endmodule
`default_nettype wire

// >>> bench/pwr_seq_props.sv
`default_nettype none
module pwr_seq_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic irq_pending_i,
  input wire logic [3:0] mode_o,
  input wire logic core_sleep_o,
  input wire logic core_deep_o,
  input wire logic periph_clk_on_o,
  input wire logic low_voltage_detect_on_o,
  input wire logic nested_irq_on_o,
  input wire logic async_wakeup_on_o,
  input wire logic regulator_low_o,
  input wire logic sram_l_on_o,
  input wire logic sram_u_on_o,
  input wire logic sram_u_part_o,
  input wire logic regfile_on_o,
  input wire logic pin_hold_o,
  input wire logic wake_reset_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_reset_run: assert property (disable iff (1'b0) rst_i |=> mode_o == 4'h0 && !core_sleep_o)
    else $error("mode not normal run after reset");
  chk_ack_answer: assert property (cyc_i && stb_i && !ack_o && ce_i |=> ack_o)
    else $error("bus request not acknowledged");
  chk_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_mode_range: assert property (mode_o <= 4'hA)
    else $error("mode code out of range");
  chk_pin_hold: assert property (pin_hold_o == (mode_o != 4'h0 && mode_o != 4'h3))
    else $error("pin hold wrong for mode");
  chk_wait_policy: assert property (mode_o == 4'h1 |-> core_sleep_o && !core_deep_o && periph_clk_on_o && nested_irq_on_o)
    else $error("wait mode controls wrong");
  chk_wait_wake: assert property (mode_o == 4'h1 && irq_pending_i |-> ##[1:3] mode_o == 4'h0)
    else $error("wait mode did not wake");
  chk_stop_policy: assert property (mode_o == 4'h2 |-> core_deep_o && !periph_clk_on_o
    && low_voltage_detect_on_o && !nested_irq_on_o && async_wakeup_on_o) else $error("stop controls wrong");
  chk_vlp_run: assert property (mode_o == 4'h3 |-> !low_voltage_detect_on_o && regulator_low_o)
    else $error("low power run controls wrong");
  chk_level_two: assert property (mode_o == 4'h8 |-> !sram_l_on_o && sram_u_part_o)
    else $error("level two memory power wrong");
  chk_level_one: assert property (mode_o == 4'h9 |-> !sram_l_on_o && !sram_u_on_o && regfile_on_o)
    else $error("level one memory power wrong");
  chk_wake_pulse: assert property (wake_reset_o |=> !wake_reset_o)
    else $error("wake reset not a single pulse");
  cov_wait: cover property (mode_o == 4'h1);
  cov_level_one: cover property (mode_o == 4'h9);
  cov_wake_reset: cover property (wake_reset_o);
endmodule
bind power_mode_controller pwr_seq_props props (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .ack_o, .irq_pending_i,
  .mode_o, .core_sleep_o, .core_deep_o, .periph_clk_on_o, .low_voltage_detect_on_o, .nested_irq_on_o,
  .async_wakeup_on_o, .regulator_low_o, .sram_l_on_o, .sram_u_on_o, .sram_u_part_o, .regfile_on_o,
  .pin_hold_o, .wake_reset_o);
`default_nettype wire

// >>> bench/core_wake_model.sv
`default_nettype none
module core_wake_model (
  input wire logic clk_i,
  input wire logic [4:0] req_i,
  output logic sleep_req_o,
  output logic irq_o,
  output logic async_o,
  output logic leak_o,
  output logic pg_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Backup supply only: main power stays absent until the bench restores it
  initial {sleep_req_o, irq_o, async_o, leak_o, pg_o} = 5'h00;
  // Sleep instruction is a one-cycle strobe so a woken core does not re-enter
  always @(posedge clk_i) begin
    sleep_req_o <= req_i[0];
    irq_o <= req_i[1];
    async_o <= req_i[2];
    leak_o <= req_i[3];
    pg_o <= req_i[4];
  end
endmodule
`default_nettype wire

// >>> bench/chip_power_mode_sequencer_bench.sv
`default_nettype none
module chip_power_mode_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [3:0] adr_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic [3:0] mode_o;
  logic [4:0] req = 5'h00;
  logic ack_o, irq_o, wake_reset_o, fs, sc, slp, irq_req, awk, lwk, pg;
  int error_cnt = 0, total_checks = 0, cyc_cnt = 0, wr_cnt = 0, fs_cnt = 0, sc_cnt = 0;
  initial forever #25 clk_i = ~clk_i;
  core_wake_model partner (.clk_i(clk_i), .req_i(req), .sleep_req_o(slp), .irq_o(irq_req), .async_o(awk),
    .leak_o(lwk), .pg_o(pg));
  power_mode_controller dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
    .wait_for_interrupt_instr_i(slp), .irq_pending_i(irq_req), .async_wake_i(awk), .leakage_wake_i(lwk),
    .power_good_i(pg), .mode_o(mode_o), .core_sleep_o(), .core_deep_o(), .periph_clk_on_o(), .fast_clk_on_o(),
    .low_voltage_detect_on_o(), .nested_irq_on_o(), .async_wakeup_on_o(), .leakage_wakeup_on_o(),
    .regulator_low_o(), .sram_l_on_o(), .sram_u_on_o(), .sram_u_part_o(), .regfile_on_o(), .main_power_o(),
    .pin_hold_o(), .flash_slow_o(fs), .slow_clk_en_o(sc), .wake_reset_o(wake_reset_o), .wake_flag_o());
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_cnt++;
    wr_cnt += wake_reset_o;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      end_sim;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic pulse(input int b);
    req[b] <= 1'b1;
    @(posedge clk_i);
    req[b] <= 1'b0;
  endtask
  // Polls the mode port for at most 60 cycles, then checks it, so a mode that never arrives is a mismatch
  task automatic wait_mode(input logic [3:0] m);
    repeat (60) if (mode_o !== m) @(posedge clk_i);
    chk(mode_o, m);
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(4'h1, 32'h0);
    rdchk(4'h0, 32'h0);
    $display("test reset done");
    for (int t = 0; t < 6; t++) begin
      wb(1'b1, 4'h0, 32'(t << 2));
      pulse(0);
      wait_mode(t == 0 ? 4'h2 : 4'(t + 5));
      req[t == 0 ? 2 : (t == 5 ? 4 : 3)] <= 1'b1;
      repeat (4) @(posedge clk_i);
      req[4] <= 1'b0;
      wait_mode(4'h0);
      req <= 5'h00;
      rdchk(4'h1, (t > 1 && t < 5) ? 32'h10 : 32'h0);
      pulse(1);
    end
    chk(wr_cnt, 4);
    $display("test stop targets done");
    wb(1'b1, 4'h0, 32'h20);
    pulse(0);
    wait_mode(4'h1);
    pulse(1);
    wait_mode(4'h0);
    wb(1'b1, 4'h0, 32'h01);
    wait_mode(4'h3);
    repeat (100) begin
      @(posedge clk_i);
      fs_cnt += fs;
      sc_cnt += sc;
    end
    chk(fs_cnt, 5);
    chk(sc_cnt, 20);
    wb(1'b1, 4'h0, 32'h21);
    pulse(0);
    wait_mode(4'h4);
    pulse(1);
    wait_mode(4'h3);
    wb(1'b1, 4'h0, 32'h01);
    pulse(0);
    wait_mode(4'h5);
    req[2] <= 1'b1;
    wait_mode(4'h3);
    req <= 5'h00;
    wb(1'b1, 4'h0, 32'h0);
    wait_mode(4'h0);
    $display("test low power done");
    ce <= 1'b0;
    pulse(0);
    repeat (6) @(posedge clk_i);
    chk(mode_o, 4'h0);
    ce <= 1'b1;
    $display("test clock enable done");
    wb(1'b1, 4'h2, 32'hF);
    wb(1'b1, 4'h3, 32'h8);
    wb(1'b1, 4'h0, 32'h18);
    pulse(0);
    repeat (8) @(posedge clk_i);
    chk(mode_o, 4'h0);
    rdchk(4'h2, 32'h8);
    chk(irq_o, 1'b1);
    wb(1'b1, 4'h3, 32'h0);
    @(posedge clk_i);
    chk(irq_o, 1'b0);
    wb(1'b1, 4'h3, 32'h8);
    @(posedge clk_i);
    chk(irq_o, 1'b1);
    wb(1'b1, 4'h2, 32'h8);
    @(posedge clk_i);
    chk(irq_o, 1'b0);
    rdchk(4'h5, 32'h0);
    wb(1'b1, 4'h0, 32'h19);
    wait_mode(4'h3);
    pulse(0);
    repeat (8) @(posedge clk_i);
    chk(mode_o, 4'h3);
    $display("test interrupts done");
    end_sim;
  end
endmodule
`default_nettype wire
